/* File: spd_regs.sv */
/*
 * Configuration register bank: PLL lock detect and charge pump control,
 * DAC control with calibration trigger, digital ramp generator parameters,
 * sticky interrupt status with mask.
 * Assumes a synchronous register port, reference clock and phase window
 * inputs synchronous to mclk, and a DAC calibrator answering with dacCalDone.
 */
// The implementer's own choice: the address-and-strobe port.
// How it works
// - lock detection follows enable bit 2
// - lock after 128/256/512/1024 in-window reference cycles
// - lock readable at bit 24 of 0x00
// - manual charge pump uses bits [5:3]
// - bit 6 clear: automatic pump during calibration
// - bit 26 clear keeps sync output active
// - calibration clock runs only with bits 25,26 clear
// - writing one to bit 24 starts calibration
// - ramp registers act only with 0x01[19] set
// - lower ramp bound held at 0x04
// - upper ramp bound held at 0x05
// - rising step size held at 0x06
// - falling step size held at 0x07
// - bits [31:16] of 0x08 set fall interval
// - bits [15:0] of 0x08 set rise interval
`timescale 1ns/1ps
`include "spd_regs_map.svh"

module spd_regs
    import spd_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // pll side
    input  wire logic        refClk,
    input  wire logic        phaseInWindow,
    input  wire logic        vcoCalBusy,
    input  wire logic [2:0]  autoCpCode,
    output logic             pllLockDetEn,
    output logic             pllLocked,
    output logic             cpManual,
    output logic      [2:0]  cpCurrent,
    // dac side
    input  wire logic        dacCalDone,
    output logic             syncOutEnable,
    output logic             dacCalClkEnable,
    output logic             dacCalStart,
    output logic             dacCalBusy,
    // ramp generator side
    output logic             rampEnable,
    output logic      [31:0] rampLowerBound,
    output logic      [31:0] rampUpperBound,
    output logic      [31:0] rampRiseStep,
    output logic      [31:0] rampFallStep,
    output logic      [15:0] rampRiseRate,
    output logic      [15:0] rampFallRate,
    // interrupt
    output logic             irq
);

    logic [6:0]     pllCtl_reg;
    logic [23:0]    dacKeep_reg;
    logic [1:0]     dacPd_reg;
    logic           rampEn_reg;
    logic [31:0]    rLow_reg;
    logic [31:0]    rHigh_reg;
    logic [31:0]    rRise_reg;
    logic [31:0]    rFall_reg;
    logic [31:0]    rRate_reg;
    logic [2:0]     irqSt_reg;
    logic [2:0]     irqMask_reg;
    logic [31:0]    rdData_reg;
    logic [31:0]    rdData_next;
    logic           refPrev_reg;
    logic           refEdge;
    logic [10:0]    lockCount_reg;
    logic [10:0]    lockTarget;
    logic           locked_reg;
    logic [2:0]     autoCp_reg;
    logic           calStart_reg;
    spd_cal_state_t calState_reg;
    logic           wordOk;
    logic [5:0]     idx;
    logic           wrHit;
    logic           calReq;
    logic [2:0]     irqEvent;

    assign idx    = regAddr[7:2];
    assign wordOk = (regAddr[1:0] == 2'h0);
    assign wrHit  = regWr && wordOk;
    assign calReq = wrHit && (idx == `SPD_IDX_DACCTL) && regWrData[`SPD_CALEN_BIT];

    // configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pllCtl_reg  <= `SPD_PLLCTL_RST;
            dacKeep_reg <= `SPD_DACCTL_RST;
            dacPd_reg   <= `SPD_DACPD_RST;
            rampEn_reg  <= 1'b0;
            rLow_reg    <= `SPD_RAMP_RST;
            rHigh_reg   <= `SPD_RAMP_RST;
            rRise_reg   <= `SPD_RAMP_RST;
            rFall_reg   <= `SPD_RAMP_RST;
            rRate_reg   <= `SPD_RAMP_RST;
            irqMask_reg <= `SPD_IRQ_RST;
        end else if (wrHit) begin
            unique case (idx)
                `SPD_IDX_SECOND: rampEn_reg <= regWrData[`SPD_RAMP_EN_BIT];
                `SPD_IDX_PLLCTL: pllCtl_reg <= regWrData[6:0];
                `SPD_IDX_DACCTL: begin
                    dacKeep_reg <= regWrData[`SPD_DAC_KEEP_MSB:0];
                    dacPd_reg   <= regWrData[`SPD_AUXPD_BIT:`SPD_CALPD_BIT];
                end
                `SPD_IDX_RLOW:   rLow_reg    <= regWrData;
                `SPD_IDX_RHIGH:  rHigh_reg   <= regWrData;
                `SPD_IDX_RRISE:  rRise_reg   <= regWrData;
                `SPD_IDX_RFALL:  rFall_reg   <= regWrData;
                `SPD_IDX_RRATE:  rRate_reg   <= regWrData;
                `SPD_IDX_IRQMSK: irqMask_reg <= regWrData[2:0];
                default: ;
            endcase
        end
    end

    // read port: data stand only in the cycle after the strobe
    always_comb begin
        rdData_next = 32'h00000000;
        if (regRd && wordOk) begin
            unique case (idx)
                `SPD_IDX_STATUS: rdData_next[`SPD_LOCK_BIT] = locked_reg;
                `SPD_IDX_SECOND: rdData_next[`SPD_RAMP_EN_BIT] = rampEn_reg;
                `SPD_IDX_PLLCTL: rdData_next[6:0] = pllCtl_reg;
                `SPD_IDX_DACCTL: begin
                    // open bits [31:27] stay zero
                    rdData_next[`SPD_AUXPD_BIT:`SPD_CALPD_BIT] = dacPd_reg;
                    rdData_next[`SPD_CALEN_BIT] = (calState_reg == CAL_RUN);
                    rdData_next[`SPD_DAC_KEEP_MSB:0] = dacKeep_reg;
                end
                `SPD_IDX_RLOW:   rdData_next = rLow_reg;
                `SPD_IDX_RHIGH:  rdData_next = rHigh_reg;
                `SPD_IDX_RRISE:  rdData_next = rRise_reg;
                `SPD_IDX_RFALL:  rdData_next = rFall_reg;
                `SPD_IDX_RRATE:  rdData_next = rRate_reg;
                `SPD_IDX_IRQST:  rdData_next[2:0] = irqSt_reg;
                `SPD_IDX_IRQMSK: rdData_next[2:0] = irqMask_reg;
                default:         rdData_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_reg <= 32'h00000000;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    // lock detection on reference clock edges
    assign refEdge    = refClk && !refPrev_reg;
    assign lockTarget = `SPD_LDW_BASE << pllCtl_reg[`SPD_LDW_MSB:`SPD_LDW_LSB];

    always_ff @(posedge mclk) begin
        if (rst) begin
            refPrev_reg <= 1'b0;
        end else begin
            refPrev_reg <= refClk;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lockCount_reg <= 11'h000;
            locked_reg    <= 1'b0;
        end else if (!pllCtl_reg[`SPD_LDE_BIT]) begin
            lockCount_reg <= 11'h000;
            locked_reg    <= 1'b0;
        end else if (refEdge) begin
            if (!phaseInWindow) begin
                lockCount_reg <= 11'h000;
                locked_reg    <= 1'b0;
            end else if (!locked_reg) begin
                if (lockCount_reg == lockTarget - 11'h001) begin
                    locked_reg <= 1'b1;
                end else begin
                    lockCount_reg <= lockCount_reg + 11'h001;
                end
            end
        end
    end

    assign pllLockDetEn = pllCtl_reg[`SPD_LDE_BIT];
    assign pllLocked    = locked_reg;

    // charge pump: manual field or code picked by the vco calibration
    always_ff @(posedge mclk) begin
        if (rst) begin
            autoCp_reg <= 3'h0;
        end else if (vcoCalBusy) begin
            autoCp_reg <= autoCpCode;
        end
    end

    assign cpManual  = pllCtl_reg[`SPD_CP_MAN_BIT];
    assign cpCurrent = cpManual ? pllCtl_reg[`SPD_CP_MSB:`SPD_CP_LSB] : autoCp_reg;

    // dac power-down controls
    assign syncOutEnable   = !dacPd_reg[1];
    assign dacCalClkEnable = !dacPd_reg[1] && !dacPd_reg[0];

    // dac calibration sequence; a trigger while running is ignored
    always_ff @(posedge mclk) begin
        if (rst) begin
            calState_reg <= CAL_IDLE;
            calStart_reg <= 1'b0;
        end else begin
            calStart_reg <= 1'b0;
            unique case (calState_reg)
                CAL_IDLE: if (calReq) begin
                    calState_reg <= CAL_RUN;
                    calStart_reg <= 1'b1;
                end
                CAL_RUN: if (dacCalDone) begin
                    calState_reg <= CAL_IDLE;
                end
                default: calState_reg <= CAL_IDLE;
            endcase
        end
    end

    assign dacCalStart = calStart_reg;
    assign dacCalBusy  = (calState_reg == CAL_RUN);

    // ramp parameters reach the generator only while enabled
    always_ff @(posedge mclk) begin
        if (rst || !rampEn_reg) begin
            rampLowerBound <= 32'h00000000;
            rampUpperBound <= 32'h00000000;
            rampRiseStep   <= 32'h00000000;
            rampFallStep   <= 32'h00000000;
            rampRiseRate   <= 16'h0000;
            rampFallRate   <= 16'h0000;
        end else begin
            rampLowerBound <= rLow_reg;
            rampUpperBound <= rHigh_reg;
            rampRiseStep   <= rRise_reg;
            rampFallStep   <= rFall_reg;
            rampRiseRate   <= rRate_reg[`SPD_RISE_RATE_MSB:0];
            rampFallRate   <= rRate_reg[31:`SPD_FALL_RATE_LSB];
        end
    end

    assign rampEnable = rampEn_reg;

    // sticky interrupt status, write one to clear, set wins
    assign irqEvent[`SPD_IRQ_LOCK]    = pllCtl_reg[`SPD_LDE_BIT] && refEdge && phaseInWindow && !locked_reg
                                        && (lockCount_reg == lockTarget - 11'h001);
    assign irqEvent[`SPD_IRQ_LOSS]    = locked_reg && refEdge && !phaseInWindow;
    assign irqEvent[`SPD_IRQ_CALDONE] = (calState_reg == CAL_RUN) && dacCalDone;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqSt_reg <= `SPD_IRQ_RST;
        end else if (wrHit && idx == `SPD_IDX_IRQST) begin
            irqSt_reg <= (irqSt_reg & ~regWrData[2:0]) | irqEvent;
        end else begin
            irqSt_reg <= irqSt_reg | irqEvent;
        end
    end

    assign irq = |(irqSt_reg & irqMask_reg);

    // checks
    lock_off_a: assert property (@(posedge mclk) disable iff (rst)
        !pllCtl_reg[`SPD_LDE_BIT] |=> !pllLocked)
        else $error("lock shown while detection disabled");

    lock_count_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(pllLocked) |-> $past(lockCount_reg) == $past(lockTarget) - 11'h001)
        else $error("lock reached at wrong count");

    lock_read_a: assert property (@(posedge mclk) disable iff (rst)
        (regRd && regAddr == 8'h00) |=> regRdData[`SPD_LOCK_BIT] == $past(pllLocked))
        else $error("lock status read mismatch");

    cp_manual_a: assert property (@(posedge mclk) disable iff (rst)
        (wrHit && idx == `SPD_IDX_PLLCTL && regWrData[`SPD_CP_MAN_BIT])
        |=> cpCurrent == $past(regWrData[`SPD_CP_MSB:`SPD_CP_LSB]))
        else $error("manual pump current not applied");

    cp_auto_a: assert property (@(posedge mclk) disable iff (rst)
        (!cpManual && vcoCalBusy && !(wrHit && idx == `SPD_IDX_PLLCTL)) |=> cpCurrent == $past(autoCpCode))
        else $error("automatic pump code not taken");

    sync_out_a: assert property (@(posedge mclk) disable iff (rst)
        (wrHit && idx == `SPD_IDX_DACCTL) |=> syncOutEnable == !$past(regWrData[`SPD_AUXPD_BIT]))
        else $error("sync output enable wrong");

    cal_clock_a: assert property (@(posedge mclk) disable iff (rst)
        (wrHit && idx == `SPD_IDX_DACCTL && (regWrData[`SPD_AUXPD_BIT] || regWrData[`SPD_CALPD_BIT]))
        |=> !dacCalClkEnable)
        else $error("calibration clock not stopped");

    cal_start_a: assert property (@(posedge mclk) disable iff (rst)
        (calReq && calState_reg == CAL_IDLE) |=> dacCalStart ##1 (!dacCalStart && dacCalBusy))
        else $error("calibration start pulse wrong");

    ramp_gate_a: assert property (@(posedge mclk) disable iff (rst)
        !rampEn_reg |=> (rampLowerBound == 32'h0 && rampRiseRate == 16'h0))
        else $error("ramp values leak while disabled");

    rate_split_a: assert property (@(posedge mclk) disable iff (rst)
        (rampEn_reg && $stable(rampEn_reg)) |-> ##1 (rampFallRate == $past(rRate_reg[31:16])
        && rampRiseRate == $past(rRate_reg[15:0])))
        else $error("ramp rate fields swapped");

    count_clear_a: assert property (@(posedge mclk) disable iff (rst)
        (refEdge && !phaseInWindow) |=> (lockCount_reg == 11'h000 && !pllLocked))
        else $error("lock count not restarted");

    open_bits_a: assert property (@(posedge mclk) disable iff (rst)
        (regRd && regAddr == 8'h0C) |=> regRdData[31:27] == 5'h00)
        else $error("open dac bits read nonzero");

    lock_rise_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(pllLocked) |-> $past(refEdge && phaseInWindow && pllLockDetEn))
        else $error("lock rose without in-window edge");

    lock_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (pllLocked && pllLockDetEn && !(refEdge && !phaseInWindow)) |=> pllLocked)
        else $error("lock dropped without cause");

    count_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !pllLockDetEn |=> lockCount_reg == 11'h000)
        else $error("lock count runs while disabled");

    cal_end_a: assert property (@(posedge mclk) disable iff (rst)
        (dacCalBusy && dacCalDone) |=> !dacCalBusy)
        else $error("calibration did not end");

    cal_ignore_a: assert property (@(posedge mclk) disable iff (rst)
        (calReq && dacCalBusy) |=> !dacCalStart)
        else $error("trigger accepted while busy");

    irq_set_a: assert property (@(posedge mclk) disable iff (rst)
        (irqEvent != 3'h0) |=> (irqSt_reg & $past(irqEvent)) == $past(irqEvent))
        else $error("interrupt event lost");

    irq_clear_a: assert property (@(posedge mclk) disable iff (rst)
        (wrHit && idx == `SPD_IDX_IRQST && irqEvent == 3'h0)
        |=> (irqSt_reg & $past(regWrData[2:0])) == 3'h0)
        else $error("interrupt status not cleared");

    ramp_values_a: assert property (@(posedge mclk) disable iff (rst)
        rampEn_reg |=> (rampLowerBound == $past(rLow_reg) && rampUpperBound == $past(rHigh_reg)
        && rampRiseStep == $past(rRise_reg) && rampFallStep == $past(rFall_reg)))
        else $error("ramp values not passed through");

    read_idle_a: assert property (@(posedge mclk) disable iff (rst)
        !regRd |=> regRdData == 32'h00000000)
        else $error("read data held past one cycle");

endmodule : spd_regs

/* File: spd_regs_map.svh */
/*
 * Register map, field positions, reset values and counts of the synthesizer
 * PLL/DAC/ramp configuration bank.
 * Assumes word registers; the byte address is four times the register index.
 */
`ifndef SPD_REGS_MAP_SVH
`define SPD_REGS_MAP_SVH

// register indices (byte address = index * 4)
`define SPD_IDX_STATUS   6'h00
`define SPD_IDX_SECOND   6'h01
`define SPD_IDX_PLLCTL   6'h02
`define SPD_IDX_DACCTL   6'h03
`define SPD_IDX_RLOW     6'h04
`define SPD_IDX_RHIGH    6'h05
`define SPD_IDX_RRISE    6'h06
`define SPD_IDX_RFALL    6'h07
`define SPD_IDX_RRATE    6'h08
`define SPD_IDX_IRQST    6'h10
`define SPD_IDX_IRQMSK   6'h11

// field positions
`define SPD_LOCK_BIT     24
`define SPD_RAMP_EN_BIT  19
`define SPD_CP_MAN_BIT   6
`define SPD_CP_MSB       5
`define SPD_CP_LSB       3
`define SPD_LDE_BIT      2
`define SPD_LDW_MSB      1
`define SPD_LDW_LSB      0
`define SPD_AUXPD_BIT    26
`define SPD_CALPD_BIT    25
`define SPD_CALEN_BIT    24
`define SPD_DAC_KEEP_MSB 23
`define SPD_FALL_RATE_LSB 16
`define SPD_RISE_RATE_MSB 15
`define SPD_IRQ_LOCK     0
`define SPD_IRQ_LOSS     1
`define SPD_IRQ_CALDONE  2

// reset values
`define SPD_PLLCTL_RST   7'h00
`define SPD_DACCTL_RST   24'h000000
`define SPD_DACPD_RST    2'h0
`define SPD_RAMP_RST     32'h00000000
`define SPD_IRQ_RST      3'h0

// lock window base count in reference cycles, doubled per select step
`define SPD_LDW_BASE     11'h080

`endif

/* File: spd_pkg.sv */
/*
 * Types of the synthesizer PLL/DAC/ramp configuration bank.
 * Assumes spd_regs_map.svh supplies all numeric constants.
 */
package spd_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } spd_cal_state_t;

    typedef enum logic [1:0] {
        LDW_128  = 2'b00,
        LDW_256  = 2'b01,
        LDW_512  = 2'b10,
        LDW_1024 = 2'b11
    } spd_ldw_t;

endpackage : spd_pkg

/* File: spd_regs_test.sv */
/*
 * Self-checking bench of the PLL/DAC/ramp configuration bank: a register model
 * held in an associative array is compared with every readback; outputs are checked against expected values, some of them random.
 * Assumes spd_regs drives registered outputs settled 1 ns after each mclk edge.
 */
`timescale 1ns/1ps

module spd_regs_test;

    logic        mclk, rst, regWr, regRd, refClk, phaseInWindow, vcoCalBusy, dacCalDone;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, d;
    logic [2:0]  autoCpCode, cpCurrent, c;
    logic        pllLockDetEn, pllLocked, cpManual, syncOutEnable, dacCalClkEnable;
    logic        dacCalStart, dacCalBusy, rampEnable, irq;
    logic [31:0] rampLowerBound, rampUpperBound, rampRiseStep, rampFallStep;
    logic [15:0] rampRiseRate, rampFallRate;
    logic [31:0] mdl [int];
    logic [31:0] v [5];
    int          errors = 0;
    int          checksDone = 0;
    int          n;

    spd_regs DUT (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .refClk(refClk), .phaseInWindow(phaseInWindow),
        .vcoCalBusy(vcoCalBusy), .autoCpCode(autoCpCode), .pllLockDetEn(pllLockDetEn),
        .pllLocked(pllLocked), .cpManual(cpManual), .cpCurrent(cpCurrent), .dacCalDone(dacCalDone),
        .syncOutEnable(syncOutEnable), .dacCalClkEnable(dacCalClkEnable), .dacCalStart(dacCalStart),
        .dacCalBusy(dacCalBusy), .rampEnable(rampEnable), .rampLowerBound(rampLowerBound),
        .rampUpperBound(rampUpperBound), .rampRiseStep(rampRiseStep), .rampFallStep(rampFallStep),
        .rampRiseRate(rampRiseRate), .rampFallRate(rampFallRate), .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        checksDone++;
        if (got !== expv) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, expv, got);
        end
    endtask : check

    // register model: masks, read-only and write-one-to-clear behaviour
    function automatic void modelWrite(input int a, input logic [31:0] wd);
        case (a)
            'h04:    mdl[a] = wd & 32'h00080000;
            'h08:    mdl[a] = wd & 32'h0000007F;
            'h0C:    mdl[a] = (wd & 32'h07FFFFFF) | (mdl[a] & 32'h01000000);
            'h10, 'h14, 'h18, 'h1C, 'h20: mdl[a] = wd;
            'h40:    mdl[a] = mdl[a] & ~wd;
            'h44:    mdl[a] = wd & 32'h00000007;
            default: ;
        endcase
    endfunction : modelWrite

    task automatic regWrite(input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= wd;
        @(posedge mclk);
        regWr <= 1'b0;
        modelWrite(a, wd);
        #1;
    endtask : regWrite

    task automatic regReadCheck(input logic [7:0] a);
        logic [31:0] e;
        e = mdl.exists(a) ? mdl[a] : 32'h00000000;
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        check($sformatf("read %h", a), e, regRdData);
    endtask : regReadCheck

    task automatic refEdges(input int cnt, input logic inWin);
        repeat (cnt) begin
            @(posedge mclk);
            refClk        <= 1'b1;
            phaseInWindow <= inWin;
            @(posedge mclk);
            refClk <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask : refEdges

    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        $display("mismatch watchdog expected finish seen hang");
        print_verdict();
    end

    initial begin
        {rst, regWr, regRd, refClk, phaseInWindow, vcoCalBusy, dacCalDone} = 7'h40;
        regAddr    = 8'h00;
        regWrData  = 32'h00000000;
        autoCpCode = 3'h0;
        foreach (v[i]) v[i] = 32'h00000000;
        for (int a = 0; a <= 'h44; a += 4) if (a <= 'h20 || a >= 'h40) mdl[a] = 32'h00000000;
        void'($urandom(32'hBF2C));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check("sync out at reset", 1'b1, syncOutEnable);
        check("cal clock at reset", 1'b1, dacCalClkEnable);
        foreach (mdl[a]) regReadCheck(8'(a));
        $display("test reset done");

        regWrite(8'h40, 32'h00000007);
        for (int w = 0; w < 4; w++) begin
            n = 128 << w;
            regWrite(8'h08, 32'h00000000);
            refEdges(4, 1'b1);
            check("lock while disabled", 1'b0, pllLocked);
            regWrite(8'h08, 32'h00000004 | w);
            check("detect enable", 1'b1, pllLockDetEn);
            refEdges(n - 1, 1'b1);
            refEdges(1, 1'b0);
            refEdges(n - 1, 1'b1);
            check("lock before count", 1'b0, pllLocked);
            refEdges(1, 1'b1);
            check("lock at count", 1'b1, pllLocked);
            mdl['h00] = 32'h01000000;
            mdl['h40] |= 32'h00000001;
            regReadCheck(8'h00);
            refEdges(1, 1'b0);
            check("lock lost", 1'b0, pllLocked);
            mdl['h00] = 32'h00000000;
            mdl['h40] |= 32'h00000002;
        end
        regReadCheck(8'h40);
        check("irq masked", 1'b0, irq);
        regWrite(8'h44, 32'h00000001);
        check("irq unmasked", 1'b1, irq);
        regWrite(8'h40, 32'h00000001);
        check("irq cleared", 1'b0, irq);
        regReadCheck(8'h40);
        $display("test lock detect done");

        regWrite(8'h44, 32'h00000004);
        d = 32'h01000000 | ($urandom() & 32'hF8000000);
        regWrite(8'h0C, d);
        check("cal start", 1'b1, dacCalStart);
        check("cal busy", 1'b1, dacCalBusy);
        @(posedge mclk);
        #1;
        check("start pulse", 1'b0, dacCalStart);
        regReadCheck(8'h0C);
        regWrite(8'h0C, d);
        check("retrigger while busy", 1'b0, dacCalStart);
        @(posedge mclk);
        dacCalDone <= 1'b1;
        @(posedge mclk);
        dacCalDone <= 1'b0;
        #1;
        check("cal end", 1'b0, dacCalBusy);
        mdl['h0C] &= ~32'h01000000;
        mdl['h40] |= 32'h00000004;
        check("cal irq", 1'b1, irq);
        regReadCheck(8'h0C);
        regReadCheck(8'h40);
        regWrite(8'h40, 32'h00000007);
        check("cal irq cleared", 1'b0, irq);
        for (int k = 0; k < 4; k++) begin
            regWrite(8'h0C, 32'(k) << 25);
            check("sync out", !k[1], syncOutEnable);
            check("cal clock", k == 0, dacCalClkEnable);
            check("no cal start", 1'b0, dacCalStart);
        end
        $display("test dac control done");

        regWrite(8'h04, 32'h00000000);
        for (int i = 0; i < 5; i++) begin
            v[i] = $urandom();
            regWrite(8'(8'h10 + 4 * i), v[i]);
            regReadCheck(8'(8'h10 + 4 * i));
        end
        check("ramp off", 32'h0, rampLowerBound | rampUpperBound | rampRiseStep | rampFallStep);
        check("rates off", 32'h0, {rampFallRate, rampRiseRate});
        regWrite(8'h04, $urandom() | 32'h00080000);
        regReadCheck(8'h04);
        check("ramp enable", 1'b1, rampEnable);
        check("lower bound", v[0], rampLowerBound);
        check("upper bound", v[1], rampUpperBound);
        check("rise step", v[2], rampRiseStep);
        check("fall step", v[3], rampFallStep);
        check("fall rate", v[4][31:16], rampFallRate);
        check("rise rate", v[4][15:0], rampRiseRate);
        regWrite(8'h04, 32'hFFF7FFFF);
        @(posedge mclk);
        #1;
        check("ramp off again", 32'h0, rampLowerBound | rampFallStep | {rampFallRate, rampRiseRate});
        $display("test ramp done");

        c = 3'($urandom());
        regWrite(8'h08, 32'h00000040 | (32'(c) << 3));
        check("manual flag", 1'b1, cpManual);
        check("manual current", c, cpCurrent);
        regReadCheck(8'h08);
        regWrite(8'h08, 32'h00000000);
        @(posedge mclk);
        vcoCalBusy <= 1'b1;
        autoCpCode <= ~c;
        @(posedge mclk);
        vcoCalBusy <= 1'b0;
        autoCpCode <= c;
        @(posedge mclk);
        #1;
        check("auto flag", 1'b0, cpManual);
        check("auto current", 3'(~c), cpCurrent);
        $display("test charge pump done");

        regWrite(8'h30, 32'hFFFFFFFF);
        regReadCheck(8'h30);
        regWrite(8'h00, 32'hFFFFFFFF);
        regReadCheck(8'h00);
        regWrite(8'h12, 32'hFFFFFFFF);
        regReadCheck(8'h10);
        regReadCheck(8'h11);
        $display("test unmapped done");
        print_verdict();
    end

endmodule : spd_regs_test
